// [verilog/scfc_pkg.sv]
package scfc_pkg;

  // Clock rate of the block and the derived timing counts.
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLK_HZ = 100_000_000;
  localparam int RESTART_TIMEOUT_US = 40;
  localparam logic [11:0] RESTART_CYCLES =
    12'(RESTART_TIMEOUT_US * 1000 / CLK_PERIOD_NS);
  localparam int OSC_HZ = 10_000_000;
  localparam logic [3:0] OSC_DIV = 4'(CLK_HZ / OSC_HZ);
  localparam logic [8:0] INIT_CYCLES = 9'h12b;

  // Register byte offsets on the bus.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LENGTH = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_BITCNT = 8'h0c;
  localparam logic [7:0] REG_LASTBYTE = 8'h10;

  // Field positions.
  localparam int CTRL_AUTO_BIT = 0;
  localparam int CTRL_USRCLK_BIT = 1;
  localparam int STAT_ERR_BIT = 0;
  localparam int STAT_USER_BIT = 1;
  localparam int STAT_STATE_LSB = 4;

  // Reset values.
  localparam logic [1:0] CTRL_RST = 2'h1;
  localparam logic [23:0] LENGTH_RST = 24'h000100;

  // Loader states, Gray coded along the normal path.
  typedef enum logic [2:0] {
    SCFC_RESET = 3'h0,
    SCFC_WAIT = 3'h1,
    SCFC_LOAD = 3'h3,
    SCFC_DONEW = 3'h2,
    SCFC_INIT = 3'h6,
    SCFC_USER = 3'h7,
    SCFC_ERROR = 3'h5
  } scfc_state_t;

  // Synchronised pin levels travel together.
  typedef struct packed {
    logic reconfig_request_n;
    logic wired_status_n;
    logic load_complete;
    logic serial_bit_clock;
    logic serial_bit_in;
    logic chain_enable_in_n;
    logic user_startup_clock;
  } scfc_pins_t;

  localparam int PINS_W = $bits(scfc_pins_t);

endpackage

// [verilog/scfc_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module scfc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  // Two flip-flops per bit; the first stage feeds only the second.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_ff;
      logic sync_ff;
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          meta_ff <= 1'b0;
          sync_ff <= 1'b0;
        end else begin
          meta_ff <= d[i];
          sync_ff <= meta_ff;
        end
      end
      assign q[i] = sync_ff;
    end
  endgenerate

endmodule
`default_nettype wire

// [verilog/scfc_tick_div.sv]
`timescale 1ns/10ps
`default_nettype none
module scfc_tick_div (
  input wire logic clk,
  input wire logic resetn,
  output logic tick
);
  import scfc_pkg::*;

  logic [3:0] cnt_ff;
  logic tick_ff;
  logic wrap;

  // One-cycle enable at the internal oscillator rate.
  assign wrap = (cnt_ff == OSC_DIV - 4'h1);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= 4'h0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= wrap ? 4'h0 : cnt_ff + 4'h1;
      tick_ff <= wrap;
    end
  end

  assign tick = tick_ff;

endmodule
`default_nettype wire

// [verilog/scfc_top.sv]
`timescale 1ns/10ps
`default_nettype none
module scfc_top (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic RECONFIG_REQUEST_N,
  input wire logic WIRED_STATUS_N_I,
  output logic WIRED_STATUS_N_O,
  output logic WIRED_STATUS_N_OE,
  input wire logic LOAD_COMPLETE_I,
  output logic LOAD_COMPLETE_O,
  output logic LOAD_COMPLETE_OE,
  input wire logic SERIAL_BIT_CLOCK,
  input wire logic SERIAL_BIT_IN,
  input wire logic CHAIN_ENABLE_IN_N,
  output logic CHAIN_ENABLE_OUT_N,
  input wire logic USER_STARTUP_CLOCK,
  output logic USER_IO_ENABLE
);
  import scfc_pkg::*;

  scfc_pins_t pins_raw;
  scfc_pins_t pins;
  scfc_pins_t pins_d_ff;
  logic osc_tick;

  scfc_state_t state_ff;
  scfc_state_t nxt_state;
  logic [1:0] ctrl_ff;
  logic [23:0] length_ff;
  logic [23:0] bitcnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] lastbyte_ff;
  logic [7:0] xsum_ff;
  logic [2:0] bitpos_ff;
  logic [11:0] tmo_ff;
  logic [8:0] init_ff;
  logic err_ff;
  logic ceo_n_ff;
  logic status_oe_ff;
  logic done_oe_ff;
  logic io_en_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;

  // Pin levels from outside the clock domain pass two flip-flops.
  assign pins_raw = '{reconfig_request_n: RECONFIG_REQUEST_N,
                      wired_status_n: WIRED_STATUS_N_I,
                      load_complete: LOAD_COMPLETE_I,
                      serial_bit_clock: SERIAL_BIT_CLOCK,
                      serial_bit_in: SERIAL_BIT_IN,
                      chain_enable_in_n: CHAIN_ENABLE_IN_N,
                      user_startup_clock: USER_STARTUP_CLOCK};

  scfc_sync #(
    .WIDTH(PINS_W)
  ) u_sync (
    .clk(CLK),
    .resetn(RESETN),
    .d(pins_raw),
    .q(pins)
  );

  scfc_tick_div u_osc (
    .clk(CLK),
    .resetn(RESETN),
    .tick(osc_tick)
  );

  // Previous synchronised levels, for edge detection.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      pins_d_ff <= '0;
    end else begin
      pins_d_ff <= pins;
    end
  end

  // Edge and condition decode.
  logic req_fall;
  logic status_fall;
  logic serial_bit_clock_rise;
  logic usr_rise;
  logic init_tick;
  logic load_active;
  logic last_bit;
  logic [7:0] byte_next;
  logic byte_full;
  logic sum_ok;
  logic tmo_done;
  logic init_done;
  logic auto_restart;

  assign req_fall = pins_d_ff.reconfig_request_n & ~pins.reconfig_request_n;
  assign status_fall = pins_d_ff.wired_status_n & ~pins.wired_status_n;
  assign serial_bit_clock_rise = ~pins_d_ff.serial_bit_clock & pins.serial_bit_clock;
  assign usr_rise = ~pins_d_ff.user_startup_clock & pins.user_startup_clock;
  assign init_tick = ctrl_ff[CTRL_USRCLK_BIT] ? usr_rise : osc_tick;
  assign load_active = (state_ff == SCFC_LOAD) & ~pins.chain_enable_in_n &
                       serial_bit_clock_rise;
  assign last_bit = (bitcnt_ff + 24'h1 == length_ff);
  assign byte_next = {shift_ff[6:0], pins_d_ff.serial_bit_in};
  assign byte_full = (bitpos_ff == 3'h7);
  assign sum_ok = ((xsum_ff ^ byte_next) == 8'h00);
  assign tmo_done = (tmo_ff == RESTART_CYCLES - 12'h1);
  assign init_done = (init_ff == INIT_CYCLES - 9'h1);
  assign auto_restart = ctrl_ff[CTRL_AUTO_BIT];

  // Next state of the loader.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SCFC_RESET: begin
        if (pins.reconfig_request_n) begin
          nxt_state = SCFC_WAIT;
        end
      end
      SCFC_WAIT: begin
        if (pins.wired_status_n) begin
          nxt_state = SCFC_LOAD;
        end
      end
      SCFC_LOAD: begin
        if (load_active && last_bit) begin
          nxt_state = (byte_full && sum_ok) ? SCFC_DONEW : SCFC_ERROR;
        end
      end
      SCFC_DONEW: begin
        if (pins.load_complete) begin
          nxt_state = SCFC_INIT;
        end
      end
      SCFC_INIT: begin
        if (init_tick && init_done) begin
          nxt_state = SCFC_USER;
        end
      end
      SCFC_USER: begin
        nxt_state = SCFC_USER;
      end
      SCFC_ERROR: begin
        if (tmo_done && auto_restart) begin
          nxt_state = SCFC_WAIT;
        end
      end
      default: begin
        nxt_state = SCFC_RESET;
      end
    endcase
    // A request fall overrides everything; a foreign status fall
    // restarts this device's loading as well.
    if (req_fall || !pins.reconfig_request_n) begin
      nxt_state = SCFC_RESET;
    end else if (status_fall && !status_oe_ff &&
                 state_ff != SCFC_ERROR && state_ff != SCFC_RESET) begin
      nxt_state = SCFC_WAIT;
    end
  end

  // State register and the pin drivers that follow it.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_ff <= SCFC_RESET;
      status_oe_ff <= 1'b1;
      done_oe_ff <= 1'b1;
      io_en_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      status_oe_ff <= (nxt_state == SCFC_RESET) ||
                      (nxt_state == SCFC_ERROR);
      done_oe_ff <= (nxt_state != SCFC_DONEW) &&
                    (nxt_state != SCFC_INIT) &&
                    (nxt_state != SCFC_USER);
      io_en_ff <= (nxt_state == SCFC_USER);
    end
  end

  // Chain enable out goes low once this device holds its image.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ceo_n_ff <= 1'b1;
    end else if (nxt_state == SCFC_DONEW || nxt_state == SCFC_INIT ||
                 nxt_state == SCFC_USER) begin
      ceo_n_ff <= 1'b0;
    end else begin
      ceo_n_ff <= 1'b1;
    end
  end

  // Serial capture: bit count, byte assembly and running check sum.
  // The waiting and error states clear the loader; other states outside loading hold it.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      bitcnt_ff <= 24'h0;
      bitpos_ff <= 3'h0;
      shift_ff <= 8'h00;
      xsum_ff <= 8'h00;
      lastbyte_ff <= 8'h00;
    end else if (state_ff != SCFC_LOAD) begin
      if (state_ff == SCFC_WAIT || state_ff == SCFC_ERROR) begin
        bitcnt_ff <= 24'h0;
        bitpos_ff <= 3'h0;
        shift_ff <= 8'h00;
        xsum_ff <= 8'h00;
      end
    end else if (load_active) begin
      bitcnt_ff <= bitcnt_ff + 24'h1;
      bitpos_ff <= bitpos_ff + 3'h1;
      shift_ff <= byte_next;
      if (byte_full) begin
        xsum_ff <= xsum_ff ^ byte_next;
        lastbyte_ff <= byte_next;
      end
    end
  end

  // Restart time-out and initialization counters.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      tmo_ff <= 12'h0;
      init_ff <= 9'h0;
    end else begin
      if (state_ff == SCFC_ERROR && !tmo_done) begin
        tmo_ff <= tmo_ff + 12'h1;
      end else if (state_ff != SCFC_ERROR) begin
        tmo_ff <= 12'h0;
      end
      if (state_ff != SCFC_INIT) begin
        init_ff <= 9'h0;
      end else if (init_tick) begin
        init_ff <= init_ff + 9'h1;
      end
    end
  end

  // Bus decode for the classic single-cycle slave.
  logic bus_req;
  logic wr_hit;
  logic wr_ctrl;
  logic wr_length;
  logic wr_status;
  logic err_set;
  logic [31:0] rd_mux;

  assign bus_req = WB_CYC_I & WB_STB_I;
  assign wr_hit = bus_req & WB_WE_I & ack_ff;
  assign wr_ctrl = wr_hit & (WB_ADR_I == REG_CTRL) & WB_SEL_I[0];
  assign wr_length = wr_hit & (WB_ADR_I == REG_LENGTH);
  assign wr_status = wr_hit & (WB_ADR_I == REG_STATUS) & WB_SEL_I[0];
  assign err_set = (nxt_state == SCFC_ERROR) && (state_ff != SCFC_ERROR);
  assign rd_mux =
    (WB_ADR_I == REG_CTRL) ? {30'h0, ctrl_ff} :
    (WB_ADR_I == REG_LENGTH) ? {8'h00, length_ff} :
    (WB_ADR_I == REG_STATUS) ? {25'h0, state_ff, 2'h0, io_en_ff, err_ff} :
    (WB_ADR_I == REG_BITCNT) ? {8'h00, bitcnt_ff} :
    (WB_ADR_I == REG_LASTBYTE) ? {24'h0, lastbyte_ff} : 32'h0;

  // Acknowledge one cycle after the request; read data latch with it.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0;
    end else begin
      ack_ff <= bus_req & ~ack_ff;
      rdata_ff <= (bus_req & ~ack_ff & ~WB_WE_I) ? rd_mux : 32'h0;
    end
  end

  // Control registers; a new error wins over a write-one clear.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_ff <= CTRL_RST;
      length_ff <= LENGTH_RST;
      err_ff <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= WB_DAT_I[1:0];
      end
      if (wr_length) begin
        if (WB_SEL_I[0]) length_ff[7:0] <= WB_DAT_I[7:0];
        if (WB_SEL_I[1]) length_ff[15:8] <= WB_DAT_I[15:8];
        if (WB_SEL_I[2]) length_ff[23:16] <= WB_DAT_I[23:16];
      end
      if (err_set) begin
        err_ff <= 1'b1;
      end else if (wr_status && WB_DAT_I[STAT_ERR_BIT]) begin
        err_ff <= 1'b0;
      end
    end
  end

  // Outputs straight from flip-flops; open-drain lines only pull low.
  assign WB_ACK_O = ack_ff;
  assign WB_DAT_O = rdata_ff;
  assign WIRED_STATUS_N_O = 1'b0;
  assign WIRED_STATUS_N_OE = status_oe_ff;
  assign LOAD_COMPLETE_O = 1'b0;
  assign LOAD_COMPLETE_OE = done_oe_ff;
  assign CHAIN_ENABLE_OUT_N = ceo_n_ff;
  assign USER_IO_ENABLE = io_en_ff;

endmodule
`default_nettype wire

// [bench/scfc_sva.sv]
`timescale 1ns/10ps
`default_nettype none
module scfc_sva (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic RECONFIG_REQUEST_N,
  input wire logic WIRED_STATUS_N_O,
  input wire logic WIRED_STATUS_N_OE,
  input wire logic LOAD_COMPLETE_I,
  input wire logic LOAD_COMPLETE_O,
  input wire logic LOAD_COMPLETE_OE,
  input wire logic CHAIN_ENABLE_OUT_N,
  input wire logic USER_STARTUP_CLOCK,
  input wire logic USER_IO_ENABLE
);
  import scfc_pkg::*;
  localparam logic [15:0] init_min =
    16'(INIT_CYCLES) * 16'(OSC_DIV) - 16'h0014;
  localparam logic [15:0] usr_min = 16'(INIT_CYCLES) - 16'h0001;
  logic [15:0] hi_cnt_ff;
  // Counts cycles for which the shared done line has stayed high.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) hi_cnt_ff <= 16'h0000;
    else if (!LOAD_COMPLETE_I) hi_cnt_ff <= 16'h0000;
    else if (hi_cnt_ff != 16'hffff) hi_cnt_ff <= hi_cnt_ff + 16'h0001;
  end
  logic usr_d_ff;
  logic [15:0] usr_cnt_ff;
  // Counts user start-up clock rises while the done line stays high.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      usr_d_ff <= 1'b0;
      usr_cnt_ff <= 16'h0000;
    end else begin
      usr_d_ff <= USER_STARTUP_CLOCK;
      if (!LOAD_COMPLETE_I) begin
        usr_cnt_ff <= 16'h0000;
      end else if (USER_STARTUP_CLOCK && !usr_d_ff &&
                   usr_cnt_ff != 16'hffff) begin
        usr_cnt_ff <= usr_cnt_ff + 16'h0001;
      end
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  wb_ack_a: assert property (
    WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("Bus request not answered in one cycle.");
  ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("Bus ack lasted more than one cycle.");
  dat_idle_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
    else $error("Read data not zero outside ack.");
  pins_low_a: assert property (
    !WIRED_STATUS_N_O && !LOAD_COMPLETE_O)
    else $error("Open-drain pin drives high.");
  req_fall_a: assert property (
    $fell(RECONFIG_REQUEST_N) |-> ##[1:6]
    (WIRED_STATUS_N_OE && LOAD_COMPLETE_OE && !USER_IO_ENABLE))
    else $error("Request fall did not pull lines.");
  req_hold_a: assert property (
    !RECONFIG_REQUEST_N [*6] |-> WIRED_STATUS_N_OE && LOAD_COMPLETE_OE)
    else $error("Lines released while request low.");
  req_rise_a: assert property (
    $rose(RECONFIG_REQUEST_N) |-> WIRED_STATUS_N_OE [*2])
    else $error("Status released before request synced.");
  err_pull_a: assert property (
    $rose(WIRED_STATUS_N_OE) |-> ##[0:1] LOAD_COMPLETE_OE)
    else $error("Status pulled without done pulled.");
  chain_out_a: assert property (
    $fell(CHAIN_ENABLE_OUT_N) |-> !LOAD_COMPLETE_OE)
    else $error("Chain out fell before own load ended.");
  init_time_a: assert property (
    $rose(USER_IO_ENABLE) |-> (hi_cnt_ff >= init_min &&
    hi_cnt_ff <= init_min + 16'h0050) ||
    (usr_cnt_ff >= usr_min && usr_cnt_ff <= usr_min + 16'h0003))
    else $error("User mode entered at wrong init count.");
  user_mode_a: assert property (
    $rose(USER_IO_ENABLE) |-> LOAD_COMPLETE_I && !CHAIN_ENABLE_OUT_N)
    else $error("User mode without done line high.");
endmodule
bind scfc_top scfc_sva i_sva (.CLK, .RESETN, .WB_CYC_I, .WB_STB_I,
  .WB_DAT_O, .WB_ACK_O, .RECONFIG_REQUEST_N, .WIRED_STATUS_N_O,
  .WIRED_STATUS_N_OE, .LOAD_COMPLETE_I, .LOAD_COMPLETE_O,
  .LOAD_COMPLETE_OE, .CHAIN_ENABLE_OUT_N, .USER_STARTUP_CLOCK,
  .USER_IO_ENABLE);
`default_nettype wire

// [bench/scfc_mem.sv]
`timescale 1ns/10ps
`default_nettype none
module scfc_mem (
  input wire logic status_n,
  input wire logic select_n,
  output logic sclk,
  output logic sdat,
  output logic oe_pull
);
  logic [7:0] img [0:63];
  int nbytes = 32;
  // Streams the image MSB first; the clock stands low between frames.
  initial begin
    sclk = 1'b0;
    sdat = 1'b1;
    oe_pull = 1'b0;
    #7;
    forever begin
      wait (status_n === 1'b1 && select_n === 1'b0);
      #3; // Keeps link edges off the block's clock edges.
      for (int i = 0; i < nbytes * 8; i++) begin
        if (status_n !== 1'b1) break;
        sdat = img[i / 8][7 - i % 8];
        #80 sclk = 1'b1;
        #80 sclk = 1'b0;
      end
      sdat = 1'b1;
      repeat (64) #160;
      if (status_n === 1'b1 && select_n === 1'b0) begin
        oe_pull = 1'b1;
        #1000 oe_pull = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [bench/scfc_top_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module scfc_top_tb;
  import scfc_pkg::*;
  logic CLK = 1'b0;
  logic RESETN = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic req = 1'b1;
  logic cein = 1'b0;
  logic uclk = 1'b0;
  logic [3:0] sel = 4'hf;
  logic [31:0] rnd;
  logic [31:0] rdat;
  logic ack, st_o, st_oe, dn_o, dn_oe, ceo, uio, sclk, sdat, mpull;
  logic [31:0] expq [$];
  int checked = 0;
  int bad_count = 0;
  int n;
  int nb;
  // Both shared lines have pull-ups; the device may pull either low, the memory only the status line.
  wire logic st_line = (st_oe ? st_o : 1'b1) & ~mpull;
  wire logic dn_line = dn_oe ? dn_o : 1'b1;
  always #5 CLK = ~CLK;
  always #20 uclk = ~uclk;
  scfc_top i_dut (.CLK, .RESETN, .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .RECONFIG_REQUEST_N(req),
    .WIRED_STATUS_N_I(st_line), .WIRED_STATUS_N_O(st_o),
    .WIRED_STATUS_N_OE(st_oe), .LOAD_COMPLETE_I(dn_line),
    .LOAD_COMPLETE_O(dn_o), .LOAD_COMPLETE_OE(dn_oe),
    .SERIAL_BIT_CLOCK(sclk), .SERIAL_BIT_IN(sdat),
    .CHAIN_ENABLE_IN_N(cein), .CHAIN_ENABLE_OUT_N(ceo),
    .USER_STARTUP_CLOCK(uclk), .USER_IO_ENABLE(uio));
  scfc_mem i_mem (.status_n(st_line), .select_n(dn_line), .sclk, .sdat,
    .oe_pull(mpull));
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // One classic bus cycle; a read notes its expected word.
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    if (!w) expq.push_back(d);
    @(posedge CLK);
    while (ack !== 1'b1 && k < 16) begin
      @(posedge CLK);
      k++;
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k == 16) bad_count++;
    @(posedge CLK);
  endtask
  // Waits, bounded, for user mode (0) or the status pull (1).
  task automatic await(input int s, input logic v);
    n = 0;
    while ((s == 0 ? uio : st_oe) !== v && n < 20000) begin
      @(posedge CLK);
      n++;
    end
    if (n == 20000) bad_count++;
  endtask
  // Fills the image; the last byte balances the XOR unless bad.
  task automatic image(input int b, input logic bad);
    logic [7:0] x;
    x = 8'h00;
    for (int i = 0; i < b - 1; i++) begin
      i_mem.img[i] = 8'($urandom);
      x ^= i_mem.img[i];
    end
    i_mem.img[b - 1] = x ^ {7'h00, bad};
    i_mem.nbytes = b;
  endtask
  task automatic pulse();
    req <= 1'b0;
    repeat (200) @(posedge CLK);
    req <= 1'b1;
    await(1, 1'b0);
  endtask
  task automatic test_done();
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Pairs each read answer with the oldest noted expectation.
  always @(posedge CLK) begin
    if (ack === 1'b1 && we === 1'b0) check(rdat, expq.pop_front());
  end
  initial begin
    #1000000;
    bad_count++;
    test_done();
  end
  // Status words: state in bits 6:4, user mode bit 1, error bit 0.
  initial begin
    void'($urandom(90));
    image(32, 1'b0);
    repeat (5) @(posedge CLK);
    RESETN <= 1'b1;
    @(posedge CLK);
    wb(1'b0, REG_CTRL, 32'h1);
    wb(1'b0, REG_LENGTH, 32'h100);
    wb(1'b1, 8'h20, 32'hffff_ffff);
    wb(1'b0, 8'h20, 32'h0);
    rnd = $urandom;
    sel <= 4'h6;
    wb(1'b1, REG_LENGTH, rnd);
    sel <= 4'he;
    wb(1'b1, REG_CTRL, 32'h0);
    sel <= 4'hf;
    wb(1'b0, REG_LENGTH, {8'h00, rnd[23:8], 8'h00});
    wb(1'b0, REG_CTRL, 32'h1);
    wb(1'b1, REG_LENGTH, 32'h100);
    await(0, 1'b1);
    check(ceo, 1'b0);
    wb(1'b0, REG_BITCNT, 32'h100);
    wb(1'b0, REG_LASTBYTE, {24'h0, i_mem.img[31]});
    wb(1'b0, REG_STATUS, 32'h72);
    $display("test power-up load done");
    image(32, 1'b1);
    pulse();
    await(1, 1'b1);
    image(32, 1'b0);
    await(1, 1'b0);
    check(n >= 3998 && n <= 4002, 1'b1);
    await(0, 1'b1);
    wb(1'b0, REG_STATUS, 32'h73);
    wb(1'b1, REG_STATUS, 32'h1);
    wb(1'b0, REG_STATUS, 32'h72);
    $display("test auto restart done");
    wb(1'b1, REG_CTRL, 32'h0);
    image(32, 1'b1);
    pulse();
    await(1, 1'b1);
    repeat (5000) @(posedge CLK);
    check(st_oe, 1'b1);
    wb(1'b0, REG_STATUS, 32'h51);
    image(32, 1'b0);
    pulse();
    await(0, 1'b1);
    $display("test manual restart done");
    wb(1'b1, REG_STATUS, 32'h1);
    wb(1'b1, REG_CTRL, 32'h3);
    wb(1'b0, REG_CTRL, 32'h3);
    image(32, 1'b0);
    pulse();
    await(0, 1'b1);
    check(n < 6000, 1'b1);
    wb(1'b0, REG_STATUS, 32'h72);
    $display("test user clock done");
    wb(1'b1, REG_STATUS, 32'h1);
    wb(1'b1, REG_CTRL, 32'h1);
    cein <= 1'b1;
    nb = 4 + $urandom % 28;
    image(nb, 1'b0);
    wb(1'b1, REG_LENGTH, 32'(nb * 8));
    pulse();
    repeat (8000) @(posedge CLK);
    check(uio, 1'b0);
    check(ceo, 1'b1);
    cein <= 1'b0;
    await(0, 1'b1);
    check(ceo, 1'b0);
    wb(1'b0, REG_BITCNT, 32'(nb * 8));
    wb(1'b0, REG_LASTBYTE, {24'h0, i_mem.img[nb - 1]});
    $display("test chain enable done");
    check(expq.size(), 0);
    test_done();
  end
endmodule
`default_nettype wire
